//--- rtl/rfid_tag_core_codec.v
// transponder digital core: gap decoder, command control, bit-rate and encoder
// Summary of operation
// [R01] all timing counted in carrier periods
// [R02] even divisors from two to 128
// [R03] compatibility mode: fixed divisor table
// [R04] gap intervals decoded, stream length validated
// [R05] first two received bits are opcode
// [R06] password bits compared against block seven
// [R07] config loaded from block zero, also reading
// [R08] config refreshed each block, after reset
// [R09] delivered config selects Manchester, RF/64
// [R10] frequency-shift subcarrier periods per mode
// [R11] phase flips whenever data changes
// [R12] phase flips at boundary when high
// [R13] phase flips only on data rise
// [R14] Manchester: falling zero, rising one
// [R15] bi-phase: extra mid-bit change for ones
// [R16] NRZ: load on for one
// [R17] reader picks rate matching subcarrier periods
// [R18] sensor high inverts whole output stream
// [R19] ten blocks, 33 bits written together
// [R20] locked block refuses any programming
// [R21] block zero skipped in continuous read unless block limit is zero
// [R22] opcode 11 sends page one blocks
// [R23] gap spacing decoded, 64-period timeout
// [R24] 192 periods init, optional 8190 hold
// [R25] read starts with zero bit, block one (block zero if block limit is zero)
// [R26] bit counter restarts at each boundary
`timescale 1ns/1ps
`include "rfid_tag_consts.vh"
module rfid_tag_core_codec #(
    parameter POR_HOLD = `POR_HOLD_PER
) (
    input  wire sys_clk,
    input  wire rst_b,
    input  wire rf_clk,
    input  wire field_on,
    input  wire sensor_hi,
    output reg  damp_on_ff,
    output wire rx_active,
    output wire tx_active
);
    localparam [4:0] S_INIT = 5'h01;
    localparam [4:0] S_HOLD = 5'h02;
    localparam [4:0] S_RX   = 5'h04;
    localparam [4:0] S_EXEC = 5'h08;
    localparam [4:0] S_READ = 5'h10;

    function [7:0] rate_div;
        input [31:0] cfg;
        begin
            if (cfg[`CFG_XMODE_BIT])
                rate_div = {1'b0, cfg[`CFG_RATE_MSB:`CFG_RATE_LSB], 1'b0} + 8'h02; // [R02]
            else
                case (cfg[`CFG_RATE_LSB+2:`CFG_RATE_LSB]) // [R03]
                    3'h0: rate_div = 8'h08;
                    3'h1: rate_div = 8'h10;
                    3'h2: rate_div = 8'h20;
                    3'h3: rate_div = 8'h28;
                    3'h4: rate_div = 8'h32;
                    3'h5: rate_div = 8'h40;
                    3'h6: rate_div = 8'h64;
                    default: rate_div = 8'h80;
                endcase
        end
    endfunction

    function [3:0] sub_per;
        input [4:0] md;
        input       d;
        begin
            case (md) // [R10]
                `MOD_FSK_A_8_5:  sub_per = d ? 4'h5 : 4'h8;
                `MOD_FSK_A_8_10: sub_per = d ? 4'ha : 4'h8;
                `MOD_FSK_5_8:    sub_per = d ? 4'h8 : 4'h5;
                `MOD_FSK_10_8:   sub_per = d ? 4'h8 : 4'ha;
                default:         sub_per = `PSK_SUB_PER;
            endcase
        end
    endfunction

    function [3:0] blk_index;
        input       pg;
        input [2:0] b;
        begin
            if (pg && b != 3'h0)
                blk_index = `P1_BASE + {1'b0, b};
            else
                blk_index = {1'b0, b};
        end
    endfunction

    reg              rf_s1_ff, rf_s2_ff, rf_s3_ff;
    reg              fld_s1_ff, fld_s2_ff, fld_s3_ff;
    reg              sen_s1_ff, sen_s2_ff;
    reg  [4:0]       state_ff;
    reg  [13:0]      cnt_ff;
    reg  [31:0]      cfg_ff;
    reg  [`SR_W-1:0] sr_ff;
    reg  [6:0]       nbit_ff;
    reg              arm_ff;
    reg  [1:0]       acc_ff;
    reg              pw_ok_ff;
    reg              page_ff, blkrd_ff, first_ff, pend_ff;
    reg  [2:0]       blk_ff;
    reg  [5:0]       bix_ff;
    reg  [1:0]       ld_ff;
    reg  [32:1]      word_ff;
    reg  [7:0]       bt_ff;
    reg  [3:0]       sc_ff;
    reg              d_ff, prev_ff, ph_ff, bp_ff, half_ff, enc_ff;
    reg              rd_en;
    reg  [3:0]       rd_addr;
    wire [`BLK_W-1:0] rd_data;
    reg              wr_en;
    reg  [`BLK_W-1:0] wr_data;

    // carrier edge is the only time base; the tick is one sys_clk wide
    wire tick      = rf_s2_ff & ~rf_s3_ff; // [R01]
    wire gap_start = fld_s3_ff & ~fld_s2_ff;
    wire gap_end   = ~fld_s3_ff & fld_s2_ff;

    wire [4:0]       mode   = cfg_ff[`CFG_MOD_MSB:`CFG_MOD_LSB];
    wire             pwen   = cfg_ff[`CFG_PWEN_BIT];
    wire [2:0]       maxb   = cfg_ff[`CFG_MAXB_MSB:`CFG_MAXB_LSB];
    // limit zero streams the config block, so the cycle must open on it too
    wire [2:0]       start_blk = (maxb == 3'h0) ? 3'h0 : 3'h1; // [R25]
    wire [7:0]       div    = rate_div(cfg_ff);
    wire [6:0]       pw_len = pwen ? `LEN_PW : 7'h00;
    wire [6:0]       lsh    = (nbit_ff <= 7'd70) ? (7'd70 - nbit_ff) : 7'd0;
    wire [`SR_W-1:0] al     = sr_ff << lsh;
    wire [1:0]       op     = al[`SR_W-1:`SR_W-2]; // [R05]
    wire [31:0]      pw     = al[`SR_W-3:`SR_W-34];
    wire [`SR_W-1:0] rest   = al << pw_len;
    wire             is_wr  = op[1] && nbit_ff == `LEN_WR + pw_len; // [R04]
    wire             is_da  = op[1] && nbit_ff == `LEN_DA + pw_len && !rest[`SR_W-3];
    wire             is_p1  = op == `OP_PAGE1 && nbit_ff == `LEN_SHORT;
    wire             is_rst = op == `OP_RESET && nbit_ff == `LEN_SHORT;
    wire [2:0]       tgt    = is_wr ? rest[`SR_W-36:`SR_W-38] : rest[`SR_W-4:`SR_W-6];
    wire [3:0]       sc_p   = sub_per(mode, d_ff);
    wire             bnd    = tick && bt_ff == div - 8'h01;
    wire             mid    = tick && bt_ff == {1'b0, div[7:1]} - 8'h01;
    wire             tx_d   = first_ff ? 1'b0 : word_ff[6'd33 - bix_ff];
    wire             zero_b = page_ff && blk_ff > 3'h2;

    assign rx_active = state_ff == S_RX;
    assign tx_active = state_ff == S_READ;

    tag_mem_blocks u_mem (
        .sys_clk    (sys_clk),
        .rst_b      (rst_b),
        .rd_en      (rd_en),
        .rd_addr    (rd_addr),
        .rd_data_ff (rd_data),
        .wr_en      (wr_en),
        .wr_addr    ({1'b0, tgt}),
        .wr_data    (wr_data)
    );

    always @*
    begin
        rd_en   = 1'b0;
        rd_addr = `CFG_BLK;
        wr_en   = 1'b0;
        wr_data = {rest[`SR_W-4:`SR_W-35], rest[`SR_W-3]};
        case (state_ff)
            S_INIT: rd_en = 1'b1; // [R07]
            S_EXEC:
            begin
                rd_en   = acc_ff != 2'h2;
                rd_addr = (acc_ff == 2'h0) ? `PW_BLK : {1'b0, tgt};
                // lock bit of the target gates the whole 33-bit write
                wr_en   = acc_ff == 2'h2 && is_wr && !op[0] && pw_ok_ff && !rd_data[0]; // [R20]
            end
            S_READ:
            begin
                rd_en   = ld_ff == 2'h1 || ld_ff == 2'h2;
                rd_addr = (ld_ff == 2'h2) ? blk_index(page_ff, blk_ff) : `CFG_BLK; // [R08]
            end
            default: rd_en = 1'b0;
        endcase
    end

    always @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rf_s1_ff  <= 1'b0;
            rf_s2_ff  <= 1'b0;
            rf_s3_ff  <= 1'b0;
            fld_s1_ff <= 1'b0;
            fld_s2_ff <= 1'b0;
            fld_s3_ff <= 1'b0;
            sen_s1_ff <= 1'b0;
            sen_s2_ff <= 1'b0;
        end
        else
        begin
            rf_s1_ff  <= rf_clk;
            rf_s2_ff  <= rf_s1_ff;
            rf_s3_ff  <= rf_s2_ff;
            fld_s1_ff <= field_on;
            fld_s2_ff <= fld_s1_ff;
            fld_s3_ff <= fld_s2_ff;
            sen_s1_ff <= sensor_hi;
            sen_s2_ff <= sen_s1_ff;
        end
    end

    always @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_ff <= S_INIT;
            cnt_ff   <= 14'h0000;
            cfg_ff   <= 32'h00000000;
            sr_ff    <= {`SR_W{1'b0}};
            nbit_ff  <= 7'h00;
            arm_ff   <= 1'b0;
            acc_ff   <= 2'h0;
            pw_ok_ff <= 1'b0;
            page_ff  <= 1'b0;
            blkrd_ff <= 1'b0;
            first_ff <= 1'b1;
            pend_ff  <= 1'b0;
            blk_ff   <= 3'h1;
            bix_ff   <= 6'h01;
            ld_ff    <= 2'h0;
            word_ff  <= 32'h00000000;
            bt_ff    <= 8'h00;
        end
        else
        begin
            case (state_ff)
                S_INIT:
                begin
                    cfg_ff <= rd_data[32:1]; // [R07]
                    if (gap_start)
                        cnt_ff <= 14'h0000;
                    else if (tick && cnt_ff == `INIT_PER - 14'h0001) // [R24]
                    begin
                        cnt_ff   <= 14'h0000;
                        state_ff <= rd_data[`CFG_PORDLY_BIT+1] ? S_HOLD : S_READ;
                        page_ff  <= 1'b0;
                        blkrd_ff <= 1'b0;
                        blk_ff   <= start_blk;
                        first_ff <= 1'b1;
                        pend_ff  <= 1'b1;
                        ld_ff    <= 2'h1;
                        bix_ff   <= 6'h01;
                        bt_ff    <= 8'h00;
                    end
                    else if (tick)
                        cnt_ff <= cnt_ff + 14'h0001;
                end
                S_HOLD:
                begin
                    if (gap_start)
                    begin
                        state_ff <= S_INIT;
                        cnt_ff   <= 14'h0000;
                    end
                    else if (tick && cnt_ff == POR_HOLD[13:0] - 14'h0001) // [R24]
                        state_ff <= S_READ;
                    else if (tick)
                        cnt_ff <= cnt_ff + 14'h0001;
                end
                S_RX:
                begin
                    if (gap_end)
                    begin
                        cnt_ff <= 14'h0000;
                        arm_ff <= 1'b1;
                    end
                    else if (gap_start && arm_ff)
                    begin
                        // midpoint between nominal spacings splits zero from one
                        sr_ff   <= {sr_ff[`SR_W-2:0], cnt_ff >= `GAP_SPLIT}; // [R23]
                        nbit_ff <= (nbit_ff == 7'h7f) ? nbit_ff : nbit_ff + 7'h01; // [R04]
                        arm_ff  <= 1'b0;
                    end
                    else if (tick && arm_ff && cnt_ff == `GAP_TIMEOUT - 14'h0001) // [R23]
                    begin
                        state_ff <= S_EXEC;
                        acc_ff   <= 2'h0;
                        arm_ff   <= 1'b0;
                    end
                    else if (tick && arm_ff)
                        cnt_ff <= cnt_ff + 14'h0001;
                end
                S_EXEC:
                begin
                    acc_ff <= acc_ff + 2'h1;
                    if (acc_ff == 2'h1)
                        pw_ok_ff <= !pwen || rd_data[32:1] == pw; // [R06]
                    if (acc_ff == 2'h2)
                    begin
                        first_ff <= 1'b1; // [R25]
                        pend_ff  <= 1'b1;
                        ld_ff    <= 2'h1;
                        bix_ff   <= 6'h01;
                        bt_ff    <= 8'h00;
                        state_ff <= S_READ;
                        page_ff  <= 1'b0;
                        blkrd_ff <= 1'b0;
                        blk_ff   <= is_p1 ? 3'h1 : start_blk;
                        if (is_rst)
                        begin
                            state_ff <= S_INIT; // [R08]
                            cnt_ff   <= 14'h0000;
                        end
                        else if (is_p1)
                            page_ff <= 1'b1; // [R22]
                        else if ((is_wr || is_da) && pw_ok_ff)
                        begin
                            page_ff  <= op[0];
                            blkrd_ff <= 1'b1;
                            blk_ff   <= tgt;
                        end
                    end
                end
                S_READ:
                begin
                    if (gap_start)
                    begin
                        state_ff <= S_RX;
                        nbit_ff  <= 7'h00;
                        arm_ff   <= 1'b0;
                    end
                    if (ld_ff == 2'h2)
                        cfg_ff <= rd_data[32:1]; // [R08]
                    if (ld_ff == 2'h3)
                        word_ff <= zero_b ? 32'h00000000 : rd_data[32:1];
                    if (ld_ff != 2'h0)
                        ld_ff <= ld_ff + 2'h1;
                    if (bnd)
                    begin
                        bt_ff   <= 8'h00; // [R26]
                        pend_ff <= 1'b1;
                        if (first_ff)
                            first_ff <= 1'b0;
                        else if (bix_ff == 6'h20)
                        begin
                            bix_ff <= 6'h01;
                            ld_ff  <= 2'h1;
                            if (!blkrd_ff)
                            begin
                                if (page_ff)
                                    blk_ff <= (blk_ff == 3'h2) ? 3'h1 : blk_ff + 3'h1;
                                else if (maxb == 3'h0)
                                    blk_ff <= 3'h0;
                                else
                                    blk_ff <= (blk_ff >= maxb) ? 3'h1 : blk_ff + 3'h1; // [R21]
                            end
                        end
                        else
                            bix_ff <= bix_ff + 6'h01;
                    end
                    else if (tick)
                        bt_ff <= bt_ff + 8'h01;
                    if (pend_ff && ld_ff == 2'h0 && !bnd)
                        pend_ff <= 1'b0;
                end
                default: state_ff <= S_INIT;
            endcase
        end
    end

    // bit start waits for a pending block load, a few sys_clk late at most
    wire bit_go = state_ff == S_READ && pend_ff && ld_ff == 2'h0 && !bnd;

    always @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            d_ff       <= 1'b0;
            prev_ff    <= 1'b0;
            ph_ff      <= 1'b0;
            bp_ff      <= 1'b0;
            half_ff    <= 1'b0;
            sc_ff      <= 4'h0;
            enc_ff     <= 1'b0;
            damp_on_ff <= 1'b0;
        end
        else
        begin
            if (bit_go)
            begin
                d_ff    <= tx_d;
                prev_ff <= tx_d;
                half_ff <= 1'b0;
                sc_ff   <= 4'h0;
                bp_ff   <= ~bp_ff;
                case (mode)
                    `MOD_PSK_CHG:  ph_ff <= ph_ff ^ (tx_d ^ prev_ff);  // [R11]
                    `MOD_PSK_HIGH: ph_ff <= ph_ff ^ tx_d;              // [R12]
                    `MOD_PSK_RISE: ph_ff <= ph_ff ^ (tx_d & ~prev_ff); // [R13]
                    default:       ph_ff <= ph_ff;
                endcase
            end
            else
            begin
                if (mid)
                begin
                    half_ff <= 1'b1;
                    bp_ff   <= bp_ff ^ d_ff; // [R15]
                end
                if (tick)
                    sc_ff <= (sc_ff >= sc_p - 4'h1) ? 4'h0 : sc_ff + 4'h1;
            end
            case (mode)
                `MOD_MANCH:    enc_ff <= half_ff ? d_ff : ~d_ff; // [R14]
                `MOD_BIPHASE:  enc_ff <= bp_ff;
                `MOD_NRZ:      enc_ff <= d_ff; // [R16]
                `MOD_PSK_CHG,
                `MOD_PSK_HIGH,
                `MOD_PSK_RISE: enc_ff <= sc_ff[0] ^ ph_ff;
                default:       enc_ff <= sc_ff < {1'b0, sc_p[3:1]}; // [R10]
            endcase
            if (state_ff == S_HOLD)
                damp_on_ff <= 1'b1; // [R24]
            else if (state_ff == S_READ)
                damp_on_ff <= enc_ff ^ sen_s2_ff; // [R18]
            else
                damp_on_ff <= 1'b0;
        end
    end
endmodule

//--- inc/rfid_tag_consts.vh
// constants for the transponder core: config fields, modes, timing
`ifndef RFID_TAG_CONSTS_VH
`define RFID_TAG_CONSTS_VH
`define BLK_W          33
`define NUM_BLK        10
`define CFG_DEFAULT    32'h00148000
`define CFG_BLK        4'h0
`define PW_BLK         4'h7
`define P1_BASE        4'h7
`define CFG_PORDLY_BIT 24
`define CFG_RATE_MSB   23
`define CFG_RATE_LSB   18
`define CFG_XMODE_BIT  17
`define CFG_MOD_MSB    16
`define CFG_MOD_LSB    12
`define CFG_MAXB_MSB   7
`define CFG_MAXB_LSB   5
`define CFG_PWEN_BIT   4
`define MOD_NRZ        5'h00
`define MOD_PSK_CHG    5'h01
`define MOD_PSK_HIGH   5'h02
`define MOD_PSK_RISE   5'h03
`define MOD_FSK_5_8    5'h04
`define MOD_FSK_10_8   5'h05
`define MOD_FSK_A_8_5  5'h06
`define MOD_FSK_A_8_10 5'h07
`define MOD_MANCH      5'h08
`define MOD_BIPHASE    5'h10
`define OP_RESET       2'h0
`define OP_PAGE1       2'h3
`define LEN_SHORT      7'h02
`define LEN_DA         7'h06
`define LEN_WR         7'h26
`define LEN_PW         7'h20
`define SR_W           70
`define INIT_PER       14'h00c0
`define POR_HOLD_PER   8190
`define GAP_ZERO_PER   24
`define GAP_ONE_PER    54
`define GAP_SPLIT      ((`GAP_ZERO_PER + `GAP_ONE_PER) / 2)
`define GAP_TIMEOUT    14'h0040
`define PSK_SUB_PER    4'h2
`endif

//--- rtl/tag_mem_blocks.v
// block memory of the transponder, registered read port
`timescale 1ns/1ps
`include "rfid_tag_consts.vh"
module tag_mem_blocks (
    input  wire              sys_clk,
    input  wire              rst_b,
    input  wire              rd_en,
    input  wire [3:0]        rd_addr,
    output reg  [`BLK_W-1:0] rd_data_ff,
    input  wire              wr_en,
    input  wire [3:0]        wr_addr,
    input  wire [`BLK_W-1:0] wr_data
);
    reg [`BLK_W-1:0] mem_ff [0:`NUM_BLK-1];
    integer          i;

    // reset stands in for the delivered contents of the non-volatile array
    always @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            for (i = 0; i < `NUM_BLK; i = i + 1)
                mem_ff[i] <= {`BLK_W{1'b0}};
            mem_ff[0] <= {`CFG_DEFAULT, 1'b0}; // [R09]
            rd_data_ff <= {`BLK_W{1'b0}};
        end
        else
        begin
            if (wr_en && wr_addr < `NUM_BLK)
                mem_ff[wr_addr] <= wr_data; // [R19]
            if (rd_en)
                rd_data_ff <= (rd_addr < `NUM_BLK) ? mem_ff[rd_addr] : {`BLK_W{1'b0}};
        end
    end
endmodule

//--- dv/rfid_tag_core_codec_asserts.sv
// port checker for the transponder core, bound to its top module
`timescale 1ns/1ps
module rfid_tag_core_codec_asserts #(
    parameter POR_HOLD = 8190
) (
    input wire sys_clk,
    input wire rst_b,
    input wire rf_clk,
    input wire field_on,
    input wire sensor_hi,
    input wire damp_on_ff,
    input wire rx_active,
    input wire tx_active
);
    // quiet window in sys_clk cycles: 64 carrier periods of 125 ns each, plus sync slack
    localparam int QUIET_MIN = 32'h384;
    localparam int QUIET_MAX = 32'h47e;
    logic [2:0]  rf_sync_ff;
    logic        damp_prev_ff;
    logic [4:0]  since_tick_ff;
    logic [10:0] quiet_ff;
    logic [8:0]  init_ticks_ff;
    logic [6:0]  run_ticks_ff;
    wire         tick = rf_sync_ff[1] & ~rf_sync_ff[2];
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);
    always @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rf_sync_ff    <= 3'h0;
            damp_prev_ff  <= 1'b0;
            since_tick_ff <= 5'h00;
            quiet_ff      <= 11'h000;
            init_ticks_ff <= 9'h000;
            run_ticks_ff  <= 7'h00;
        end
        else
        begin
            rf_sync_ff    <= {rf_sync_ff[1:0], rf_clk};
            damp_prev_ff  <= damp_on_ff;
            since_tick_ff <= tick ? 5'h00 : since_tick_ff + {4'h0, ~&since_tick_ff};
            quiet_ff      <= !field_on ? 11'h000 : quiet_ff + {10'h000, ~&quiet_ff};
            // counters saturate so a stuck design cannot wrap back into range
            init_ticks_ff <= (!field_on || rx_active || tx_active) ? 9'h000
                           : init_ticks_ff + {8'h00, tick & ~&init_ticks_ff};
            run_ticks_ff  <= (!tx_active || damp_on_ff != damp_prev_ff) ? 7'h00
                           : run_ticks_ff + {6'h00, tick & ~&run_ticks_ff};
        end
    end
    rx_tx_excl_a : assert property (!(rx_active && tx_active))
        else $error("receive and transmit active together");
    rx_from_read_a : assert property ($rose(rx_active) |->
        $past(tx_active) && !$past(field_on))
        else $error("reception entered outside read or without gap");
    quiet_exit_a : assert property ($fell(rx_active) |-> quiet_ff >= QUIET_MIN)
        else $error("reception left before quiet window");
    rx_bounded_a : assert property (rx_active |-> quiet_ff <= QUIET_MAX)
        else $error("reception outlived quiet window");
    tx_exit_gap_a : assert property ($fell(tx_active) |-> rx_active)
        else $error("read mode left without a gap");
    tick_aligned_a : assert property ($changed(damp_on_ff) && tx_active
        && $past(tx_active, 3) |-> since_tick_ff <= 5'h0c)
        else $error("load change not aligned to carrier");
    manch_run_a : assert property (tx_active |-> run_ticks_ff <= 7'h44)
        else $error("no transition within one bit");
    init_len_a : assert property ($rose(tx_active) |-> init_ticks_ff <= 9'h002
        || (init_ticks_ff >= 9'h0bc && init_ticks_ff <= 9'h0c4))
        else $error("init length wrong");
    tx_start_c : cover property ($rose(tx_active));
    rx_end_c : cover property ($fell(rx_active));
    invert_c : cover property (tx_active && $rose(sensor_hi));
endmodule
bind rfid_tag_core_codec rfid_tag_core_codec_asserts #(.POR_HOLD(POR_HOLD)) i_asserts (
    .sys_clk(sys_clk), .rst_b(rst_b), .rf_clk(rf_clk), .field_on(field_on),
    .sensor_hi(sensor_hi), .damp_on_ff(damp_on_ff), .rx_active(rx_active),
    .tx_active(tx_active));

//--- dv/reader_model.sv
// reader model: carrier source and gap-coded downlink sender
`timescale 1ns/1ps
module reader_model (
    output logic rf_clk,
    output logic field_on
);
    initial
    begin
        rf_clk = 1'b0;
        field_on = 1'b1;
    end
    // carrier dies during a gap, so no ticks are seen there
    always #62.5 rf_clk = field_on ? ~rf_clk : 1'b0;
    task automatic wait_ticks(input int n);
        repeat (n) @(posedge rf_clk);
    endtask
    task automatic gap;
        field_on = 1'b0;
        #1000;
        field_on = 1'b1;
    endtask
    // msb first; no password bits since protection is off in the delivered setup
    task automatic send_cmd(input logic [39:0] bits, input int n);
        gap();
        for (int i = n - 1; i >= 0; i--)
        begin
            wait_ticks(bits[i] ? 54 : 24);
            gap();
        end
    endtask
endmodule

//--- dv/testbench.sv
// self-checking bench for the transponder core
`timescale 1ns/1ps
module testbench;
    localparam logic [31:0] CFG  = 32'h00148000;
    localparam logic [31:0] WORD = 32'hc3a50f0f;
    logic sys_clk;
    logic rst_b;
    logic sensor_hi;
    wire  rf_clk;
    wire  field_on;
    wire  damp_on_ff;
    wire  rx_active;
    wire  tx_active;
    int   failures;
    int   total_checks;
    int   cycles;
    int   n;
    rfid_tag_core_codec #(.POR_HOLD(20)) i_dut (
        .sys_clk    (sys_clk),
        .rst_b      (rst_b),
        .rf_clk     (rf_clk),
        .field_on   (field_on),
        .sensor_hi  (sensor_hi),
        .damp_on_ff (damp_on_ff),
        .rx_active  (rx_active),
        .tx_active  (tx_active)
    );
    reader_model i_reader (
        .rf_clk   (rf_clk),
        .field_on (field_on)
    );
    initial sys_clk = 1'b0;
    always #4 sys_clk = ~sys_clk;
    task automatic end_of_test;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // ceiling above the roughly 78k cycles the sequence needs, kept under 100k
    always @(posedge sys_clk)
    begin
        cycles = cycles + 1;
        if (cycles == 95000)
        begin
            failures++;
            $display("BAD %0t run hung", $time);
            end_of_test();
        end
    end
    task automatic check_bit(input logic got, input logic exp, input string what);
        @(negedge sys_clk);
        total_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("BAD %0t %s got %b exp %b", $time, what, got, exp);
        end
    endtask
    task automatic check_range(input int got, input int lo, input int hi, input string what);
        total_checks++;
        if (got < lo || got > hi)
        begin
            failures++;
            $display("BAD %0t %s got %0d exp %0d..%0d", $time, what, got, lo, hi);
        end
    endtask
    task automatic wait_tx(output int ticks);
        ticks = 0;
        while (tx_active !== 1'b1 && ticks < 400)
        begin
            @(posedge rf_clk);
            ticks++;
        end
    endtask
    // one manchester bit at RF/64, halves sampled mid-way to tolerate sync lag
    task automatic read_bit(input logic b, input logic inv);
        @(negedge sys_clk);
        sensor_hi = inv;
        repeat (16) @(posedge rf_clk);
        check_bit(damp_on_ff, ~b ^ inv, "first half");
        repeat (32) @(posedge rf_clk);
        check_bit(damp_on_ff, b ^ inv, "second half");
        // a full 64 ticks per call, else the sample points drift a tick per bit
        repeat (16) @(posedge rf_clk);
    endtask
    initial
    begin
        rst_b = 1'b0;
        sensor_hi = 1'b0;
        failures = 0;
        total_checks = 0;
        cycles = 0;
        repeat (10) @(negedge sys_clk);
        check_bit(damp_on_ff | rx_active | tx_active, 1'b0, "outputs in reset");
        rst_b = 1'b1;
        wait_tx(n);
        check_range(n, 188, 196, "power-up init ticks");
        read_bit(1'b0, 1'b0);
        for (int k = 0; k < 20; k++)
            read_bit(CFG[31 - k], k >= 8 && k < 12);
        i_reader.send_cmd(40'h0000000000, 2);
        check_bit(rx_active, 1'b1, "receiving");
        i_reader.wait_ticks(50);
        check_bit(rx_active, 1'b1, "still receiving");
        i_reader.wait_ticks(20);
        check_bit(rx_active | tx_active, 1'b0, "reset command reinit");
        i_reader.wait_ticks(100);
        i_reader.gap();
        wait_tx(n);
        check_range(n, 188, 196, "init restart after gap");
        read_bit(1'b0, 1'b0);
        for (int k = 0; k < 4; k++)
            read_bit(CFG[31 - k], 1'b0);
        // block 1 only, so rate and mode stay as delivered
        i_reader.send_cmd({4'h2, 1'b0, WORD, 3'h1}, 38);
        wait_tx(n);
        check_range(n, 60, 72, "quiet ticks before execution");
        read_bit(1'b0, 1'b0);
        for (int k = 0; k < 12; k++)
            read_bit(WORD[31 - k], 1'b0);
        end_of_test();
    end
endmodule
